/* tlp_error_priority_and_route_check.sv */
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module tlp_error_priority_and_route_check (
    // Clock, reset and enable
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Received TLP descriptor
    input wire logic tlp_valid_i,
    input wire logic [2:0] tlp_kind_i,
    input wire logic non_posted_i,
    input wire logic vendor_i,
    input wire logic primary_side_i,
    input wire logic final_target_i,
    // Raw error detections
    input wire logic overflow_i,
    input wire logic ecrc_err_i,
    input wire logic malformed_i,
    input wire logic acs_block_i,
    input wire logic mcast_block_i,
    input wire logic poisoned_i,
    // Address and ID decode results
    input wire logic hit_upstream_i,
    input wire logic hit_other_dsp_i,
    input wire logic hit_ingress_i,
    input wire logic to_upstream_i,
    input wire logic vga_route_i,
    input wire logic via_usp_bridge_i,
    input wire logic conv_at_usp_i,
    input wire logic conv_at_dsp_i,
    input wire logic [4:0] target_dev_i,
    input wire logic targets_dsp_i,
    input wire logic route_valid_i,
    input wire logic cpl_internal_i,
    input wire logic targets_enabled_port_i,
    // Handling result
    output logic res_valid_o,
    output logic fwd_o,
    output logic fwd_upstream_o,
    output logic drop_o,
    output logic nullify_o,
    output logic ur_cpl_o,
    output logic ca_cpl_o,
    output logic log_valid_o,
    output logic [3:0] log_code_o
);
    // =========================================================
    // Register state
    logic [tlp_chk_pkg::CTRL_WIDTH-1:0] ctrl;
    logic [tlp_chk_pkg::CTRL_WIDTH-1:0] next_ctrl;
    logic [31:0] dev_enable;
    logic [31:0] next_dev_enable;
    logic [31:0] next_rdata;
    tlp_chk_pkg::log_state_type log_state;
    tlp_chk_pkg::log_state_type next_log_state;
    logic [3:0] first_code;
    logic [3:0] next_first_code;
    logic [tlp_chk_pkg::COUNT_WIDTH-1:0] log_count;
    logic [tlp_chk_pkg::COUNT_WIDTH-1:0] next_log_count;

    // =========================================================
    // Result state
    logic next_res_valid;
    logic next_fwd;
    logic next_fwd_upstream;
    logic next_drop;
    logic next_nullify;
    logic next_ur_cpl;
    logic next_ca_cpl;
    logic next_log_valid;
    tlp_chk_pkg::err_code_type next_log_code;

    // =========================================================
    // Routing checker
    route_chk_if rci ();

    assign rci.kind = tlp_chk_pkg::tlp_kind_type'(tlp_kind_i);
    assign rci.is_up = ctrl[tlp_chk_pkg::CTRL_IS_UP];
    assign rci.mem_space_enable = ctrl[tlp_chk_pkg::CTRL_MEM_EN];
    assign rci.io_space_enable = ctrl[tlp_chk_pkg::CTRL_IO_EN];
    assign rci.master_enable = ctrl[tlp_chk_pkg::CTRL_MASTER_EN];
    assign rci.usp_master_enable = ctrl[tlp_chk_pkg::CTRL_USP_MASTER_EN];
    assign rci.up_fwd_enable = ctrl[tlp_chk_pkg::CTRL_UP_FWD];
    assign rci.alt_routing_id_enable = ctrl[tlp_chk_pkg::CTRL_ALT_ID];
    assign rci.vga_enable = ctrl[tlp_chk_pkg::CTRL_VGA_EN];
    assign rci.dev_enable = dev_enable;
    assign rci.primary_side = primary_side_i;
    assign rci.hit_upstream = hit_upstream_i;
    assign rci.hit_other_dsp = hit_other_dsp_i;
    assign rci.hit_ingress = hit_ingress_i;
    assign rci.to_upstream = to_upstream_i;
    assign rci.vga_route = vga_route_i;
    assign rci.via_usp_bridge = via_usp_bridge_i;
    assign rci.conv_at_usp = conv_at_usp_i;
    assign rci.conv_at_dsp = conv_at_dsp_i;
    assign rci.target_dev = target_dev_i;
    assign rci.targets_dsp = targets_dsp_i;
    assign rci.route_valid = route_valid_i;
    assign rci.cpl_internal = cpl_internal_i;
    assign rci.vendor = vendor_i;
    assign rci.targets_enabled_port = targets_enabled_port_i;

    route_checker u_route_checker (
        .rc(rci.checker_end)
    );

    // =========================================================
    // Parallel error evaluation
    // All checks are computed in the same cycle; a TLP that an earlier check
    // removes from the stream gates the actions of the later ones, while the
    // log only ever sees the top detection.
    logic ecrc_det;
    logic live;
    logic malf_det;
    logic acs_det;
    logic mcast_det;
    logic ur_det;
    logic uc_det;
    logic poison_det;
    logic silent;
    logic [tlp_chk_pkg::ERR_WIDTH-1:0] det;
    logic [tlp_chk_pkg::ERR_WIDTH-1:0] top_hit;
    logic [tlp_chk_pkg::ERR_WIDTH:0] above;

    always_comb begin
        ecrc_det = ecrc_err_i && !overflow_i;
        live = !(ecrc_det && final_target_i);
        malf_det = malformed_i && live;
        acs_det = acs_block_i && live && !malf_det;
        mcast_det = mcast_block_i && live && !malf_det && !acs_det;
        ur_det = rci.route_err && live && !malf_det && !acs_det && !mcast_det;
        uc_det = rci.cpl_unexpected && live && !malf_det && !acs_det && !mcast_det;
        silent = (rci.cpl_drop || rci.silent_discard) && live && !malf_det && !acs_det && !mcast_det;
        poison_det = poisoned_i && live && !malf_det && !acs_det && !mcast_det && !ur_det
            && !uc_det && !silent;
        det = {overflow_i, ecrc_det, malf_det, acs_det, mcast_det, ur_det, uc_det, poison_det};
    end

    // Bit k of det wins only when no higher bit is set.
    assign above[tlp_chk_pkg::ERR_WIDTH] = 1'b0;
    genvar gi;
    generate
        for (gi = tlp_chk_pkg::ERR_WIDTH - 1; gi >= 0; gi--) begin : g_prio
            assign top_hit[gi] = det[gi] && !above[gi+1];
            assign above[gi] = above[gi+1] || det[gi];
        end
    endgenerate

    // =========================================================
    // Handling actions and log selection
    always_comb begin
        next_res_valid = tlp_valid_i;
        next_drop = 1'b0;
        next_nullify = 1'b0;
        next_ur_cpl = 1'b0;
        next_ca_cpl = 1'b0;
        next_fwd = 1'b0;
        next_fwd_upstream = 1'b0;
        next_log_valid = 1'b0;
        next_log_code = tlp_chk_pkg::ERR_NONE;
        if (tlp_valid_i) begin
            if (!live) begin
                next_drop = 1'b1;
            end else if (malf_det) begin
                next_nullify = 1'b1;
            end else if (acs_det) begin
                next_drop = 1'b1;
                next_ca_cpl = non_posted_i && !ecrc_det;
            end else if (mcast_det) begin
                next_drop = 1'b1;
            end else if (ur_det) begin
                next_drop = 1'b1;
                next_ur_cpl = non_posted_i && !ecrc_det;
            end else if (uc_det || silent) begin
                next_drop = 1'b1;
            end else begin
                // Overflow acts only by masking ECRC detection; ECRC and poison may cross.
                next_fwd = 1'b1;
                next_fwd_upstream = rci.fwd_up;
            end
            next_log_valid = |top_hit;
            case (1'b1)
                top_hit[7]: next_log_code = tlp_chk_pkg::ERR_OVFL;
                top_hit[6]: next_log_code = tlp_chk_pkg::ERR_ECRC;
                top_hit[5]: next_log_code = tlp_chk_pkg::ERR_MALF;
                top_hit[4]: next_log_code = tlp_chk_pkg::ERR_ACS;
                top_hit[3]: next_log_code = tlp_chk_pkg::ERR_MCAST;
                top_hit[2]: next_log_code = tlp_chk_pkg::ERR_UR;
                top_hit[1]: next_log_code = tlp_chk_pkg::ERR_UNEXP_CPL;
                top_hit[0]: next_log_code = tlp_chk_pkg::ERR_POISON;
                default: next_log_code = tlp_chk_pkg::ERR_NONE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            res_valid_o <= 1'b0;
            fwd_o <= 1'b0;
            fwd_upstream_o <= 1'b0;
            drop_o <= 1'b0;
            nullify_o <= 1'b0;
            ur_cpl_o <= 1'b0;
            ca_cpl_o <= 1'b0;
            log_valid_o <= 1'b0;
            log_code_o <= 4'h0;
        end else if (ce_i) begin
            res_valid_o <= next_res_valid;
            fwd_o <= next_fwd;
            fwd_upstream_o <= next_fwd_upstream;
            drop_o <= next_drop;
            nullify_o <= next_nullify;
            ur_cpl_o <= next_ur_cpl;
            ca_cpl_o <= next_ca_cpl;
            log_valid_o <= next_log_valid;
            log_code_o <= next_log_code;
        end
    end

    // =========================================================
    // Register file and error log
    // A new logged error in the same cycle as a clear re-captures, so no
    // event is lost to the clear.
    always_comb begin
        next_ctrl = ctrl;
        next_dev_enable = dev_enable;
        next_log_state = log_state;
        next_first_code = first_code;
        next_log_count = log_count;
        next_rdata = 32'h0000_0000;
        if (wr_i) begin
            case (addr_i)
                tlp_chk_pkg::ADDR_CTRL: next_ctrl = wdata_i[tlp_chk_pkg::CTRL_WIDTH-1:0];
                tlp_chk_pkg::ADDR_DEV_EN: next_dev_enable = wdata_i;
                tlp_chk_pkg::ADDR_LOG_CLEAR: begin
                    if (wdata_i[tlp_chk_pkg::LOG_HELD_BIT]) next_log_state = tlp_chk_pkg::LOG_OPEN;
                end
                default: next_ctrl = ctrl;
            endcase
        end
        if (next_log_valid) begin
            if (log_count != tlp_chk_pkg::COUNT_MAX) next_log_count = log_count + 16'h0001;
            case (log_state)
                tlp_chk_pkg::LOG_OPEN: begin
                    next_log_state = tlp_chk_pkg::LOG_HELD;
                    next_first_code = next_log_code;
                end
                tlp_chk_pkg::LOG_HELD: begin
                    if (next_log_state == tlp_chk_pkg::LOG_OPEN) begin
                        next_log_state = tlp_chk_pkg::LOG_HELD;
                        next_first_code = next_log_code;
                    end
                end
                default: next_log_state = tlp_chk_pkg::LOG_HELD;
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                tlp_chk_pkg::ADDR_CTRL: next_rdata = {24'h000000, ctrl};
                tlp_chk_pkg::ADDR_DEV_EN: next_rdata = dev_enable;
                tlp_chk_pkg::ADDR_LOG: next_rdata = {27'h0000000, log_state == tlp_chk_pkg::LOG_HELD, first_code};
                tlp_chk_pkg::ADDR_COUNT: next_rdata = {16'h0000, log_count};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= tlp_chk_pkg::CTRL_RST;
            dev_enable <= tlp_chk_pkg::DEV_EN_RST;
            log_state <= tlp_chk_pkg::LOG_OPEN;
            first_code <= 4'h0;
            log_count <= 16'h0000;
            rdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ctrl <= next_ctrl;
            dev_enable <= next_dev_enable;
            log_state <= next_log_state;
            first_code <= next_first_code;
            log_count <= next_log_count;
            rdata_o <= next_rdata;
        end
    end

endmodule : tlp_error_priority_and_route_check

`default_nettype wire

/* tlp_chk_pkg.sv */
package tlp_chk_pkg;

    typedef enum logic [2:0] {
        KIND_MEM = 3'h0,
        KIND_IO = 3'h1,
        KIND_CFG0 = 3'h2,
        KIND_CFG1 = 3'h3,
        KIND_CPL = 3'h4,
        KIND_MSG_ID = 3'h5,
        KIND_MSG_BCAST = 3'h6,
        KIND_OTHER = 3'h7
    } tlp_kind_type;

    typedef enum logic [3:0] {
        ERR_NONE = 4'h0,
        ERR_POISON = 4'h1,
        ERR_UNEXP_CPL = 4'h2,
        ERR_UR = 4'h3,
        ERR_MCAST = 4'h4,
        ERR_ACS = 4'h5,
        ERR_MALF = 4'h6,
        ERR_ECRC = 4'h7,
        ERR_OVFL = 4'h8
    } err_code_type;

    typedef enum logic [0:0] {
        LOG_OPEN = 1'b0,
        LOG_HELD = 1'b1
    } log_state_type;

    // =========================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DEV_EN = 8'h04;
    localparam logic [7:0] ADDR_LOG = 8'h08;
    localparam logic [7:0] ADDR_LOG_CLEAR = 8'h0C;
    localparam logic [7:0] ADDR_COUNT = 8'h10;

    localparam int CTRL_IS_UP = 0;
    localparam int CTRL_MEM_EN = 1;
    localparam int CTRL_IO_EN = 2;
    localparam int CTRL_MASTER_EN = 3;
    localparam int CTRL_USP_MASTER_EN = 4;
    localparam int CTRL_UP_FWD = 5;
    localparam int CTRL_ALT_ID = 6;
    localparam int CTRL_VGA_EN = 7;
    localparam int CTRL_WIDTH = 8;

    localparam int LOG_HELD_BIT = 4;
    localparam int COUNT_WIDTH = 16;
    localparam int ERR_WIDTH = 8;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [31:0] DEV_EN_RST = 32'h0000_0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

endpackage : tlp_chk_pkg

/* route_chk_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface route_chk_if;
    tlp_chk_pkg::tlp_kind_type kind;
    logic is_up;
    logic mem_space_enable;
    logic io_space_enable;
    logic master_enable;
    logic usp_master_enable;
    logic up_fwd_enable;
    logic alt_routing_id_enable;
    logic vga_enable;
    logic [31:0] dev_enable;
    logic primary_side;
    logic hit_upstream;
    logic hit_other_dsp;
    logic hit_ingress;
    logic to_upstream;
    logic vga_route;
    logic via_usp_bridge;
    logic conv_at_usp;
    logic conv_at_dsp;
    logic [4:0] target_dev;
    logic targets_dsp;
    logic route_valid;
    logic cpl_internal;
    logic vendor;
    logic targets_enabled_port;
    logic route_err;
    logic cpl_drop;
    logic cpl_unexpected;
    logic silent_discard;
    logic fwd_up;

    modport checker_end (
        input kind, is_up, mem_space_enable, io_space_enable, master_enable, usp_master_enable,
        input up_fwd_enable, alt_routing_id_enable, vga_enable, dev_enable, primary_side,
        input hit_upstream, hit_other_dsp, hit_ingress, to_upstream, vga_route, via_usp_bridge,
        input conv_at_usp, conv_at_dsp, target_dev, targets_dsp, route_valid, cpl_internal,
        input vendor, targets_enabled_port,
        output route_err, cpl_drop, cpl_unexpected, silent_discard, fwd_up
    );

    modport core_end (
        output kind, is_up, mem_space_enable, io_space_enable, master_enable, usp_master_enable,
        output up_fwd_enable, alt_routing_id_enable, vga_enable, dev_enable, primary_side,
        output hit_upstream, hit_other_dsp, hit_ingress, to_upstream, vga_route, via_usp_bridge,
        output conv_at_usp, conv_at_dsp, target_dev, targets_dsp, route_valid, cpl_internal,
        output vendor, targets_enabled_port,
        input route_err, cpl_drop, cpl_unexpected, silent_discard, fwd_up
    );
endinterface : route_chk_if

`default_nettype wire

/* route_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module route_checker (
    route_chk_if.checker_end rc
);
    logic dev_present;
    logic back_to_ingress;

    always_comb begin
        dev_present = rc.dev_enable[rc.target_dev];
        back_to_ingress = rc.hit_ingress && !rc.is_up;
        rc.route_err = 1'b0;
        rc.cpl_drop = 1'b0;
        rc.cpl_unexpected = 1'b0;
        rc.silent_discard = 1'b0;
        rc.fwd_up = 1'b0;
        case (rc.kind)
            tlp_chk_pkg::KIND_MEM, tlp_chk_pkg::KIND_IO: begin
                if (rc.is_up && rc.hit_upstream && !rc.hit_other_dsp) rc.route_err = 1'b1;
                if (!rc.is_up && !rc.hit_other_dsp && rc.hit_upstream) rc.route_err = 1'b1;
                if (back_to_ingress) begin
                    if (rc.up_fwd_enable) rc.fwd_up = 1'b1;
                    else rc.route_err = 1'b1;
                end
                if (rc.primary_side && rc.kind == tlp_chk_pkg::KIND_MEM && !rc.mem_space_enable) begin
                    rc.route_err = 1'b1;
                end
                if (rc.primary_side && rc.kind == tlp_chk_pkg::KIND_IO && !rc.io_space_enable) begin
                    rc.route_err = 1'b1;
                end
                if (!rc.is_up && !rc.master_enable) rc.route_err = 1'b1;
                if (!rc.is_up && rc.to_upstream && !rc.usp_master_enable) rc.route_err = 1'b1;
                if (!rc.is_up && rc.vga_route && rc.vga_enable) rc.route_err = 1'b1;
            end
            tlp_chk_pkg::KIND_CFG0, tlp_chk_pkg::KIND_CFG1: begin
                if (!rc.is_up) rc.route_err = 1'b1;
                if (rc.kind == tlp_chk_pkg::KIND_CFG1 && rc.is_up && !rc.via_usp_bridge) begin
                    rc.route_err = 1'b1;
                end
                if (rc.conv_at_usp && !dev_present) rc.route_err = 1'b1;
                if (rc.conv_at_dsp && rc.target_dev != 5'h00 && !rc.alt_routing_id_enable) begin
                    rc.route_err = 1'b1;
                end
            end
            tlp_chk_pkg::KIND_CPL: begin
                if (!rc.route_valid) rc.cpl_drop = 1'b1;
                else if (rc.cpl_internal) rc.cpl_unexpected = 1'b1;
                else if (back_to_ingress) begin
                    if (rc.up_fwd_enable) rc.fwd_up = 1'b1;
                    else rc.cpl_drop = 1'b1;
                end
            end
            tlp_chk_pkg::KIND_MSG_ID: begin
                if (!rc.route_valid) rc.route_err = 1'b1;
                if (rc.targets_dsp && !dev_present) rc.route_err = 1'b1;
                if (back_to_ingress) begin
                    if (rc.up_fwd_enable) rc.fwd_up = 1'b1;
                    else rc.route_err = 1'b1;
                end
            end
            tlp_chk_pkg::KIND_MSG_BCAST: begin
                if (rc.vendor) rc.silent_discard = 1'b1;
                else if (rc.targets_enabled_port || rc.is_up) rc.route_err = 1'b1;
            end
            default: begin
                rc.route_err = 1'b0;
            end
        endcase
    end
endmodule : route_checker

`default_nettype wire

/* tlp_chk_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ========
// Result checks for one received descriptor.
module tlp_chk_checker (
    // Clock, reset and descriptor
    input wire logic mclk_i, rst_i, ce_i, tlp_valid_i, non_posted_i, final_target_i,
    // Raw detections
    input wire logic overflow_i, ecrc_err_i, malformed_i, acs_block_i, mcast_block_i,
    // Result
    input wire logic res_valid_o, fwd_o, drop_o, nullify_o, ca_cpl_o, log_valid_o,
    input wire logic [3:0] log_code_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_take; tlp_valid_i && ce_i; endsequence
    sequence s_ecrc; s_take ##0 (ecrc_err_i && !overflow_i); endsequence
    property p_answer; s_take |=> res_valid_o; endproperty
    a_answer: assert property (p_answer) else $error("no result");
    property p_idle; ce_i && !tlp_valid_i |=> !res_valid_o && !log_valid_o; endproperty
    a_idle: assert property (p_idle) else $error("result without descriptor");
    property p_ovfl; s_take ##0 overflow_i |=> log_valid_o && log_code_o == 4'h8; endproperty
    a_ovfl: assert property (p_ovfl) else $error("overflow not logged");
    property p_ecrc; s_ecrc |=> log_valid_o && log_code_o == 4'h7; endproperty
    a_ecrc: assert property (p_ecrc) else $error("ecrc not logged");
    property p_final; s_ecrc ##0 final_target_i |=> drop_o && !fwd_o && !nullify_o; endproperty
    a_final: assert property (p_final) else $error("final target kept it");
    property p_malf; s_take ##0 (malformed_i && !(ecrc_err_i && final_target_i)) |=> nullify_o && !fwd_o; endproperty
    a_malf: assert property (p_malf) else $error("malformed not nullified");
    property p_malf_log; s_take ##0 (malformed_i && !ecrc_err_i && !overflow_i) |=> log_code_o == 4'h6; endproperty
    a_malf_log: assert property (p_malf_log) else $error("malformed not logged");
    property p_acs_quiet; s_ecrc ##0 (acs_block_i && !final_target_i && !malformed_i) |=> drop_o && !ca_cpl_o;
    endproperty
    a_acs_quiet: assert property (p_acs_quiet) else $error("loud acs block");
    property p_acs_log; s_take ##0 (acs_block_i && non_posted_i && !ecrc_err_i && !overflow_i && !malformed_i)
        |=> ca_cpl_o && drop_o && log_code_o == 4'h5; endproperty
    a_acs_log: assert property (p_acs_log) else $error("acs not handled");
    property p_mcast; s_take ##0 (mcast_block_i && !acs_block_i && !malformed_i && !ecrc_err_i && !overflow_i)
        |=> drop_o && log_code_o == 4'h4; endproperty
    a_mcast: assert property (p_mcast) else $error("mcast not handled");
endmodule : tlp_chk_checker
bind tlp_error_priority_and_route_check tlp_chk_checker chk_u (.*);
`default_nettype wire

/* link_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ========
// Far side: hands one descriptor per send request.
module link_partner (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic send_i,
    input wire logic [29:0] desc_i,
    output logic tlp_valid_o,
    output logic [29:0] desc_o
);
    // Between descriptors the fields toggle, so stale values can never pass for a real one.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tlp_valid_o <= 1'b0;
            desc_o <= 30'h0;
        end else begin
            tlp_valid_o <= send_i;
            desc_o <= send_i ? desc_i : ~desc_o;
        end
    end
endmodule : link_partner
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, send = 1'b0, ce = 1'b1, tv;
    logic [7:0] addr_i = 8'h0;
    logic [31:0] wdata_i = 32'h0, rdata_o, r;
    logic [29:0] desc = 30'h0, d, x;
    logic rv, fw, fu, dr, nu, ur, ca, lv;
    logic [3:0] lc, first = 4'h0;
    int failures = 0, checked = 0, logged = 0;
    integer seed = 32'h9018C765;
    always #25 mclk_i = ~mclk_i;
    link_partner lp_u (.mclk_i(mclk_i), .rst_i(rst_i), .send_i(send), .desc_i(desc), .tlp_valid_o(tv), .desc_o(d));
    tlp_error_priority_and_route_check dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tlp_valid_i(tv), .tlp_kind_i(d[29:27]),
        .non_posted_i(d[26]), .vendor_i(d[25]), .primary_side_i(d[24]), .final_target_i(d[23]), .overflow_i(d[22]),
        .ecrc_err_i(d[21]), .malformed_i(d[20]), .acs_block_i(d[19]), .mcast_block_i(d[18]), .poisoned_i(d[17]),
        .hit_upstream_i(d[16]), .hit_other_dsp_i(d[15]), .hit_ingress_i(d[14]), .to_upstream_i(d[13]),
        .vga_route_i(d[12]), .via_usp_bridge_i(d[11]), .conv_at_usp_i(d[10]), .conv_at_dsp_i(d[9]),
        .target_dev_i(d[8:4]), .targets_dsp_i(d[3]), .route_valid_i(d[2]), .cpl_internal_i(d[1]),
        .targets_enabled_port_i(d[0]), .res_valid_o(rv), .fwd_o(fw), .fwd_upstream_o(fu), .drop_o(dr),
        .nullify_o(nu), .ur_cpl_o(ur), .ca_cpl_o(ca), .log_valid_o(lv), .log_code_o(lc));
    task report_and_stop;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask : rd
    // Expected {drop, nullify, ur, ca, fwd, fwd_up, code} for a clean routed memory request.
    function automatic logic [9:0] exp_of(input logic [29:0] x);
        logic [9:0] e;
        if (x[21] && x[23]) e = 10'h200;
        else if (x[20]) e = 10'h100;
        else if (x[19]) e = {3'b100, x[26] && !x[21], 6'h0};
        else if (x[18]) e = 10'h200;
        else e = 10'h020;
        e[3:0] = x[22] ? 4'h8 : x[21] ? 4'h7 : x[20] ? 4'h6 : x[19] ? 4'h5 : x[18] ? 4'h4 : {3'h0, x[17] && e[5]};
        return e;
    endfunction : exp_of
    task tlp(input logic [7:0] c, input logic [29:0] v, input logic [9:0] e);
        wr(tlp_chk_pkg::ADDR_CTRL, {24'h0, c});
        @(posedge mclk_i);
        send <= 1'b1;
        desc <= v;
        @(posedge mclk_i);
        send <= 1'b0;
        @(posedge mclk_i);
        #1 chk({rv, lv, dr, nu, ur, ca, fw, fu, lc}, {1'b1, e[3:0] != 4'h0, e});
        if (e[3:0] != 4'h0) logged++;
        if (first == 4'h0) first = e[3:0];
    endtask : tlp
    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        report_and_stop;
    end
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(tlp_chk_pkg::ADDR_CTRL, 32'h0);
        rd(tlp_chk_pkg::ADDR_COUNT, 32'h0);
        wr(tlp_chk_pkg::ADDR_COUNT, 32'hFFFF);
        rd(tlp_chk_pkg::ADDR_COUNT, 32'h0);
        rd(8'h14, 32'h0);
        wr(tlp_chk_pkg::ADDR_CTRL, 32'hFFFFFFFF);
        rd(tlp_chk_pkg::ADDR_CTRL, 32'hFF);
        wr(tlp_chk_pkg::ADDR_DEV_EN, 32'h2);
        rd(tlp_chk_pkg::ADDR_DEV_EN, 32'h2);
        tlp(8'h18, 30'h05008004, 10'h283);
        tlp(8'h16, 30'h04008004, 10'h283);
        tlp(8'h16, 30'h04208004, 10'h207);
        tlp(8'h1A, 30'h04004004, 10'h283);
        tlp(8'h3A, 30'h04004004, 10'h030);
        tlp(8'h9A, 30'h04009004, 10'h283);
        tlp(8'h1B, 30'h04010004, 10'h283);
        tlp(8'h1A, 30'h04010004, 10'h283);
        tlp(8'h1A, 30'h14000004, 10'h283);
        tlp(8'h1B, 30'h1C000A14, 10'h283);
        tlp(8'h5B, 30'h1C000A14, 10'h020);
        tlp(8'h1A, 30'h20004004, 10'h200);
        tlp(8'h3A, 30'h20004004, 10'h030);
        tlp(8'h1A, 30'h20000006, 10'h202);
        tlp(8'h1A, 30'h28000000, 10'h203);
        tlp(8'h1A, 30'h32000004, 10'h200);
        tlp(8'h1B, 30'h30000004, 10'h203);
        tlp(8'h1A, 30'h30000005, 10'h203);
        tlp(8'h1A, 30'h0D008004, 10'h283);
        tlp(8'h0A, 30'h0400A004, 10'h283);
        tlp(8'h1B, 30'h1C000004, 10'h283);
        tlp(8'h1B, 30'h1C000C04, 10'h283);
        tlp(8'h1B, 30'h1C000C14, 10'h020);
        tlp(8'h1A, 30'h2800000C, 10'h203);
        tlp(8'h1A, 30'h2800001C, 10'h020);
        tlp(8'h1A, 30'h28004004, 10'h203);
        tlp(8'h3A, 30'h28004004, 10'h030);
        tlp(8'h1A, 30'h20000000, 10'h200);
        tlp(8'h16, 30'h04028004, 10'h283);
        for (int i = 0; i < 200; i++) begin
            r = $random(seed);
            x = 30'h00008004 | (r[29:0] & 30'h04FE0000);
            if (x[22]) x[21] = 1'b0;
            tlp(8'h1A, x, exp_of(x));
        end
        // Clock enable low: a malformed descriptor must leave no result and no log entry.
        @(posedge mclk_i);
        ce <= 1'b0;
        send <= 1'b1;
        desc <= 30'h04108004;
        @(posedge mclk_i);
        send <= 1'b0;
        @(posedge mclk_i);
        #1 chk({rv, lv, dr, nu, fw}, 32'h0);
        @(posedge mclk_i);
        ce <= 1'b1;
        rd(tlp_chk_pkg::ADDR_LOG, {27'h0, 1'b1, first});
        rd(tlp_chk_pkg::ADDR_COUNT, logged);
        wr(tlp_chk_pkg::ADDR_LOG_CLEAR, 32'h10);
        rd(tlp_chk_pkg::ADDR_LOG, {27'h0, 1'b0, first});
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire
